// ---- core/tsp_pkg.sv ----
package tsp_pkg;

   // ------------------------------------------------------------
   // Framing and filter constants
   // ------------------------------------------------------------
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_FULL = 4'h8;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [1:0] FILT_LAST = 2'h2;
   localparam logic [1:0] FILT_ZERO = 2'h0;
   localparam logic [6:0] ADDR_ZERO = 7'h00;

   // ------------------------------------------------------------
   // Protocol states, Gray coded along the usual path
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_RX   = 3'h1,
      S_RACK = 3'h3,
      S_TX   = 3'h2,
      S_TACK = 3'h6
   } tsp_state_type;

   // Received byte handed to the register file.
   typedef struct packed {
      logic [7:0] data;
      logic first;
      logic valid;
   } tsp_rx_type;

   localparam tsp_rx_type RX_RESET = '{data: 8'h00, first: 1'b0, valid: 1'b0};

endpackage

// ---- core/tsp_target.sv ----
// Functional notes
// - Sample SDA on SCL rising edge, change driven SDA after SCL falling edge.
// - All bytes travel most significant bit first.
// - Each byte is eight data bits plus one acknowledge cycle.
// - Transmitter changes SDA only while SCL is low.
// - SDA falling with SCL high is a Start, beginning a new transfer.
// - SDA rising with SCL high is a Stop, returning to idle.
// - Watch for Start always; drive nothing until one is seen.
// - Bus is idle only when SCL and SDA are both high.
// - Any number of data bytes between Start and Stop.
// - Repeated Start ends the transfer and restarts address reception.
// - Drive SDA low through the whole ninth cycle after a received byte.
// - Master NACK on read makes the device release SDA.
// - Invalid writes are answered with NACK.
// - Address is fixed 4-bit prefix plus three strap pins.
// - First byte holds address in bits 7..1, direction in bit 0.
// - Acknowledge a matching address; NACK and go idle on mismatch.
// - SDA is open drain: pull low or release.
module tsp_target
   import tsp_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary device-type prefix value.
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [2:0] addr_strap_pins_i,
   output tsp_rx_type rx_o,
   input wire logic wr_refuse_i,
   output logic rd_req_o,
   input wire logic [7:0] tx_byte_i,
   output logic busy_o
);

   // ------------------------------------------------------------
   // Link clock domain
   // ------------------------------------------------------------
   logic lbit_q, ltog_q;

   // rising edge capture
   // The bit is held until the next rising edge, so the toggle qualifies it safely.
   always_ff @(posedge scl_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lbit_q <= 1'b0;
         ltog_q <= 1'b0;
      end else begin
         lbit_q <= sda_i;
         ltog_q <= ~ltog_q;
      end
   end

   // ------------------------------------------------------------
   // Crossings and pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] tog_s_q, strap_s1_q, strap_s2_q;
   logic [1:0] pin_s1_q, pin_s2_q;
   // Toggle crossing for bit events; the third flop is only for the edge compare.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tog_s_q <= 3'h0;
         strap_s1_q <= 3'h0;
         strap_s2_q <= 3'h0;
      end else begin
         tog_s_q <= {tog_s_q[1:0], ltog_q};
         strap_s1_q <= addr_strap_pins_i;
         strap_s2_q <= strap_s1_q;
      end
   end

   // idle both high
   // Bit 1 is SCL, bit 0 is SDA; lines reset to the idle high level.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_q <= 2'h3;
         pin_s2_q <= 2'h3;
      end else begin
         pin_s1_q <= {scl_i, sda_i};
         pin_s2_q <= pin_s1_q;
      end
   end

   // ------------------------------------------------------------
   // Glitch filters
   // ------------------------------------------------------------
   logic [1:0] flt_q, flt_prev_q;
   logic [1:0] fcnt_q [2];
   // deglitch filter
   // A level must hold for three samples; shorter spikes never reach the decoder.
   for (genvar g = 0; g < 2; g++) begin : g_filt
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            flt_q[g] <= 1'b1;
            fcnt_q[g] <= FILT_ZERO;
         end else if (pin_s2_q[g] == flt_q[g]) begin
            fcnt_q[g] <= FILT_ZERO;
         end else if (fcnt_q[g] == FILT_LAST) begin
            flt_q[g] <= pin_s2_q[g];
            fcnt_q[g] <= FILT_ZERO;
         end else begin
            fcnt_q[g] <= fcnt_q[g] + 2'h1;
         end
      end
   end
   // One cycle of history on the filtered lines feeds the edge and condition decode.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flt_prev_q <= 2'h3;
      end else begin
         flt_prev_q <= flt_q;
      end
   end
   logic start_evt, stop_evt, scl_fall, bit_evt;
   logic [6:0] own_addr;
   assign start_evt = flt_q[1] && flt_prev_q[1] && flt_prev_q[0] && !flt_q[0];
   assign stop_evt = flt_q[1] && flt_prev_q[1] && !flt_prev_q[0] && flt_q[0];
   assign scl_fall = flt_prev_q[1] && !flt_q[1];
   assign bit_evt = tog_s_q[1] ^ tog_s_q[2];
   assign own_addr = {DEV_TYPE, strap_s2_q};

   // ------------------------------------------------------------
   // Protocol engine
   // ------------------------------------------------------------
   tsp_state_type state_q;
   logic [3:0] cnt_q;
   logic [7:0] rx_sh_q, tx_sh_q;
   logic addr_q, rw_q, ack_q, more_q, first_q, full;
   // A byte is complete once all eight bits are counted.
   assign full = (cnt_q == BIT_FULL);
   // abort on conditions
   // Start and Stop override every state so a torn byte leaves no trace.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= S_IDLE;
         cnt_q <= BIT_ZERO;
         rx_sh_q <= 8'h00;
         tx_sh_q <= 8'h00;
         addr_q <= 1'b0;
         rw_q <= 1'b0;
         ack_q <= 1'b0;
         more_q <= 1'b0;
         first_q <= 1'b0;
         sda_oe_o <= 1'b0;
         rd_req_o <= 1'b0;
         rx_o <= RX_RESET;
      end else begin
         rd_req_o <= 1'b0;
         rx_o.valid <= 1'b0;
         if (stop_evt) begin
            state_q <= S_IDLE;
            sda_oe_o <= 1'b0;
         end else if (start_evt) begin
            state_q <= S_RX;
            addr_q <= 1'b1;
            cnt_q <= BIT_ZERO;
            sda_oe_o <= 1'b0;
         end else begin
            case (state_q)
               S_IDLE: begin
                  sda_oe_o <= 1'b0;
               end
               S_RX: begin
                  if (bit_evt && !full) begin
                     rx_sh_q <= {rx_sh_q[6:0], lbit_q};
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == BIT_FULL - 4'h1) begin
                        if (addr_q) begin
                           ack_q <= (rx_sh_q[6:0] == own_addr);
                           rw_q <= lbit_q;
                           first_q <= 1'b1;
                           rd_req_o <= lbit_q && (rx_sh_q[6:0] == own_addr);
                        end else begin
                           rx_o.data <= {rx_sh_q[6:0], lbit_q};
                           rx_o.first <= first_q;
                           rx_o.valid <= 1'b1;
                           first_q <= 1'b0;
                        end
                     end
                  end else if (scl_fall && full) begin
                     cnt_q <= BIT_ZERO;
                     if (addr_q && !ack_q) begin
                        state_q <= S_IDLE;
                     end else if (addr_q) begin
                        state_q <= S_RACK;
                        sda_oe_o <= 1'b1;
                     end else begin
                        state_q <= S_RACK;
                        ack_q <= !wr_refuse_i;
                        sda_oe_o <= !wr_refuse_i;
                     end
                  end
               end
               S_RACK: begin
                  // ninth cycle ends on its falling edge
                  if (scl_fall) begin
                     addr_q <= 1'b0;
                     cnt_q <= BIT_ZERO;
                     if (rw_q) begin
                        state_q <= S_TX;
                        tx_sh_q <= tx_byte_i;
                        sda_oe_o <= !tx_byte_i[7];
                     end else begin
                        state_q <= S_RX;
                        sda_oe_o <= 1'b0;
                     end
                  end
               end
               S_TX: begin
                  if (bit_evt && !full) begin
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall) begin
                     if (full) begin
                        state_q <= S_TACK;
                        sda_oe_o <= 1'b0;
                     end else begin
                        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                        sda_oe_o <= !tx_sh_q[6];
                     end
                  end
               end
               S_TACK: begin
                  if (bit_evt) begin
                     more_q <= !lbit_q;
                     rd_req_o <= !lbit_q;
                  end else if (scl_fall) begin
                     cnt_q <= BIT_ZERO;
                     if (more_q) begin
                        state_q <= S_TX;
                        tx_sh_q <= tx_byte_i;
                        sda_oe_o <= !tx_byte_i[7];
                     end else begin
                        state_q <= S_IDLE;
                        sda_oe_o <= 1'b0;
                     end
                  end
               end
               default: begin
                  state_q <= S_IDLE;
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end
   // open drain output
   // The data level is always low; only the enable moves.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         busy_o <= (state_q != S_IDLE);
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_addr_miss;
      state_q == S_RX && addr_q && full && !ack_q && scl_fall;
   endsequence
   sequence s_enter_tx;
      state_q != S_TX ##1 state_q == S_TX;
   endsequence
   property p_idle_silent;
      @(posedge mclk_i) disable iff (!rst_n_i) state_q == S_IDLE |-> !sda_oe_o;
   endproperty
   a_idle_silent: assert property (p_idle_silent) else $error("SDA driven while idle.");
   property p_drive_on_fall;
      @(posedge mclk_i) disable iff (!rst_n_i) $rose(sda_oe_o) |-> $past(scl_fall);
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall) else $error("SDA pulled low off a falling edge.");
   property p_stop_idle;
      @(posedge mclk_i) disable iff (!rst_n_i) stop_evt |=> state_q == S_IDLE && !sda_oe_o;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("Stop did not return to idle.");
   property p_start_addr;
      @(posedge mclk_i) disable iff (!rst_n_i)
         start_evt && !stop_evt |=> state_q == S_RX && addr_q && cnt_q == BIT_ZERO;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("Start did not restart addressing.");
   property p_addr_miss;
      @(posedge mclk_i) disable iff (!rst_n_i)
         s_addr_miss and (!start_evt && !stop_evt) |=> state_q == S_IDLE;
   endproperty
   a_addr_miss: assert property (p_addr_miss) else $error("Address mismatch not dropped.");
   property p_ack_held;
      @(posedge mclk_i) disable iff (!rst_n_i) state_q == S_RACK && ack_q |-> sda_oe_o;
   endproperty
   a_ack_held: assert property (p_ack_held) else $error("Acknowledge released early.");
   property p_refuse;
      @(posedge mclk_i) disable iff (!rst_n_i)
         state_q == S_RX && !addr_q && full && scl_fall && wr_refuse_i && !start_evt && !stop_evt
         |=> state_q == S_RACK && !sda_oe_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("Refused write was acknowledged.");
   property p_master_nack;
      @(posedge mclk_i) disable iff (!rst_n_i)
         state_q == S_TACK && scl_fall && !more_q && !start_evt && !stop_evt |=> state_q == S_IDLE && !sda_oe_o;
   endproperty
   a_master_nack: assert property (p_master_nack) else $error("SDA kept after master NACK.");
   property p_tx_msb;
      @(posedge mclk_i) disable iff (!rst_n_i) s_enter_tx |-> sda_oe_o == !tx_sh_q[7];
   endproperty
   a_tx_msb: assert property (p_tx_msb) else $error("First sent bit is not the MSB.");
   property p_bit_bound;
      @(posedge mclk_i) disable iff (!rst_n_i) cnt_q <= BIT_FULL;
   endproperty
   a_bit_bound: assert property (p_bit_bound) else $error("Bit count passed eight.");
   property p_filter;
      @(posedge mclk_i) disable iff (!rst_n_i)
         $changed(flt_q[1]) |-> $past(pin_s2_q[1], 3) == flt_q[1] && $past(pin_s2_q[1], 2) == flt_q[1];
   endproperty
   a_filter: assert property (p_filter) else $error("Filter passed a short spike.");

endmodule

// ---- bench/tsp_master.sv ----
// ------------------------------------------------------------
// Bus master model
// ------------------------------------------------------------
module tsp_master
   import tsp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // The clock stands high and data is released between frames.
   // idle both high
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end

   // Waits a number of system clocks; every bit phase lasts twelve of them.
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   // One bit: data moves only in the low phase and is read mid high phase.
   // change while low
   task automatic bit_x(input logic b, output logic r);
      sda_oe_o <= ~b;
      wt(6);
      scl_o <= 1'b1;
      wt(6);
      r = sda_i;
      wt(6);
      scl_o <= 1'b0;
      wt(6);
   endtask

   // Data falls while the clock is high; also serves as a repeated start.
   task automatic start_c();
      sda_oe_o <= 1'b0;
      wt(6);
      scl_o <= 1'b1;
      wt(12);
      sda_oe_o <= 1'b1;
      wt(12);
      scl_o <= 1'b0;
      wt(6);
   endtask

   // Data rises while the clock is high, leaving the bus idle.
   task automatic stop_c();
      sda_oe_o <= 1'b1;
      wt(6);
      scl_o <= 1'b1;
      wt(12);
      sda_oe_o <= 1'b0;
      wt(12);
   endtask

   // A one-clock dip on data while idle, far too short to be a start.
   task automatic glitch();
      sda_oe_o <= 1'b1;
      wt(1);
      sda_oe_o <= 1'b0;
      wt(10);
   endtask

   // Eight bits without pause, then the acknowledge slot; ab=1 releases it.
   // byte framing
   task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic ar);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r[i]);
      end
      bit_x(ab, ar);
   endtask
endmodule

// ---- bench/temp_sensor_serial_target_port_test.sv ----
// ------------------------------------------------------------
// Testbench top
// ------------------------------------------------------------
module temp_sensor_serial_target_port_test
   import tsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] DEV = 4'ha; // Arbitrary device-type prefix.
   localparam logic [2:0] STRAP = 3'h5;
   logic mclk, rst_n, scl, sda, m_oe, d_oe, d_sda, wr_refuse, rd_req, busy, ar;
   // Only the register-file stand-in writes these, so they start from known values here.
   logic rx_first = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic [7:0] tx_byte = 8'h3c;
   logic [7:0] r8, t0;
   tsp_rx_type rx;
   int fail_count = 0;
   int checks_done = 0;
   int rx_cnt = 0;
   int cyc = 0;
   int n;

   // Open-drain wire with a pull-up: low whenever either party pulls.
   assign sda = ~(m_oe | (d_oe & ~d_sda));

   tsp_master M (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

   tsp_target #(.DEV_TYPE(DEV)) DUT (.mclk_i(mclk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(d_sda),
      .sda_oe_o(d_oe), .addr_strap_pins_i(STRAP), .rx_o(rx), .wr_refuse_i(wr_refuse), .rd_req_o(rd_req),
      .tx_byte_i(tx_byte), .busy_o(busy));

   // System clock, 100 ns period.
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Register-file stand-in and hang guard; the next byte is the inverse of the last.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rx.valid === 1'b1) begin
         rx_data <= rx.data;
         rx_first <= rx.first;
         rx_cnt <= rx_cnt + 1;
      end
      if (rd_req === 1'b1) begin
         tx_byte <= ~tx_byte;
      end
      if (cyc == 20000) begin
         fail_count++;
         $display("Run stopped by cycle limit");
         tally_and_finish();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Two data bytes, the second refused, then a stop.
   task automatic t_write();
      M.start_c();
      M.xfer({DEV, STRAP, 1'b0}, 1'b1, r8, ar);
      chk({7'h0, ar}, 8'h00);
      n = rx_cnt;
      M.xfer(8'hb4, 1'b1, r8, ar);
      chk({7'h0, ar}, 8'h00);
      chk(rx_data, 8'hb4);
      chk({7'h0, rx_first}, 8'h01);
      wr_refuse <= 1'b1;
      M.xfer(8'h69, 1'b1, r8, ar);
      chk({7'h0, ar}, 8'h01);
      chk({7'h0, rx_first}, 8'h00);
      chk(8'(rx_cnt - n), 8'h02);
      wr_refuse <= 1'b0;
      M.stop_c();
      chk({7'h0, busy}, 8'h00);
      $display("Write test finished");
   endtask

   // Wrong prefix, then wrong strap bits: no answer at all, and a short glitch is ignored.
   task automatic t_mismatch();
      for (int k = 0; k < 2; k++) begin
         M.start_c();
         M.xfer(k == 0 ? {DEV ^ 4'h8, STRAP, 1'b0} : {DEV, STRAP ^ 3'h2, 1'b0}, 1'b1, r8, ar);
         chk({7'h0, ar}, 8'h01);
         M.xfer(8'h00, 1'b1, r8, ar);
         chk({7'h0, ar}, 8'h01);
         chk({7'h0, busy}, 8'h00);
         M.stop_c();
      end
      M.glitch();
      chk({7'h0, busy}, 8'h00);
      $display("Mismatch test finished");
   endtask

   // Write address, repeated start into a read of two bytes ended by a no-acknowledge.
   task automatic t_read();
      M.start_c();
      M.xfer({DEV, STRAP, 1'b0}, 1'b1, r8, ar);
      chk({7'h0, ar}, 8'h00);
      t0 = tx_byte;
      M.start_c();
      M.xfer({DEV, STRAP, 1'b1}, 1'b1, r8, ar);
      chk({7'h0, ar}, 8'h00);
      M.xfer(8'hff, 1'b0, r8, ar);
      chk(r8, ~t0);
      M.xfer(8'hff, 1'b1, r8, ar);
      chk(r8, t0);
      M.wt(4);
      chk({7'h0, sda}, 8'h01);
      chk({7'h0, busy}, 8'h00);
      M.stop_c();
      $display("Read test finished");
   endtask

   // A start and then a stop arriving in mid byte.
   task automatic t_abort();
      M.start_c();
      M.xfer({DEV, STRAP, 1'b0}, 1'b1, r8, ar);
      n = rx_cnt;
      for (int i = 0; i < 3; i++) begin
         M.bit_x(1'b0, ar);
      end
      M.start_c();
      M.xfer({DEV, STRAP, 1'b0}, 1'b1, r8, ar);
      chk({7'h0, ar}, 8'h00);
      for (int i = 0; i < 5; i++) begin
         M.bit_x(1'b1, ar);
      end
      M.stop_c();
      chk({7'h0, busy}, 8'h00);
      chk(8'(rx_cnt - n), 8'h00);
      $display("Abort test finished");
   endtask

   // Reset, settle, then the scenarios in turn.
   initial begin
      rst_n = 1'b0;
      wr_refuse = 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (10) @(posedge mclk);
      t_write();
      t_mismatch();
      t_read();
      t_abort();
      tally_and_finish();
   end
endmodule
